// ==== clpf_pkg.sv ====
// Constants, types and lookup tables for the camera link packet framer.
// Assumes byte-wide transfer to and from a physical layer on the link byte clock.
package clpf_pkg;

  // Payload type code classes
  localparam logic [5:0] TYPE_SHORT_MAX = 6'h0F;
  localparam logic [5:0] TYPE_LONG_MIN  = 6'h10;
  localparam logic [5:0] TYPE_LONG_MAX  = 6'h37;
  localparam logic [5:0] TYPE_RSVD_MIN  = 6'h38;

  // Identifier byte field positions
  localparam int DI_CHAN_MSB = 7;
  localparam int DI_CHAN_LSB = 6;
  localparam int DI_TYPE_MSB = 5;
  localparam int DI_TYPE_LSB = 0;

  // Packet geometry in bytes
  localparam logic [16:0] HDR_BYTES = 17'h0_0004;
  localparam logic [16:0] FTR_BYTES = 17'h0_0002;
  localparam logic [1:0]  HDR_LAST  = 2'h3;

  // Footer checksum: reflected polynomial and seed, processed LSB first
  localparam logic [15:0] CRC_POLY = 16'h8408;
  localparam logic [15:0] CRC_SEED = 16'hFFFF;

  // Reset values
  localparam logic [1:0] CHAN_RESET = 2'h0;

  // Header check-byte syndrome of each of the 24 protected header bits
  localparam logic [5:0] ECC_SYN [24] = '{
    6'h07, 6'h0B, 6'h0D, 6'h0E, 6'h13, 6'h15, 6'h16, 6'h19,
    6'h1A, 6'h1C, 6'h23, 6'h25, 6'h26, 6'h29, 6'h2A, 6'h2C,
    6'h31, 6'h32, 6'h34, 6'h38, 6'h1F, 6'h2F, 6'h37, 6'h3B
  };

  // Header decoding outcome
  typedef enum logic [1:0] {
    ECC_OK,
    ECC_FIXED,
    ECC_FATAL
  } clpf_ecc_t;

  // Event bit positions toward the system domain
  localparam int EV_FIXED = 0;
  localparam int EV_FATAL = 1;
  localparam int EV_CRC   = 2;
  localparam int EV_TYPE  = 3;
  localparam int EV_NUM   = 4;

endpackage

// ==== clpf_framer.sv ====
// Packet builder and parser for the camera serial link, byte level.
// Assumes the physical layer does start and end sequences and low power
// handling, gives one byte per link clock while active, and holds its
// transmit ready high from the first accepted byte until the request drops.
`timescale 1ns/10ps

// Operation
// - Each packet opens with leaving low power and start sequence, closes with end sequence.
// - Type codes 0x10 to 0x37 mark long packets on both ends.
// - Long packet is 32-bit header, payload bytes, 16-bit checksum footer.
// - Header order is identifier byte, 16-bit length or data, check byte.
// - Length field counts payload bytes only, no header or footer.
// - Check byte generated; receiver corrects single and detects double header errors.
// - Receiver consumes exactly length payload bytes, no sync search inside.
// - Next two bytes after payload are taken as the footer checksum.
// - Payload is whole bytes; stricter granularity is the sender's duty.
// - Each byte goes on the wire least significant bit first.
// - Length, checksum and short data travel low byte first.
// - After end sequence receiver hunts for the next start sequence.
// - Type codes 0x00 to 0x0F mark short packets.
// - Short packet is header only; its 16-bit field holds data.
// - Frame sync data carries frame number, line sync carries line number.
// - Generic short packet data passes through uninterpreted.
// - Identifier byte holds channel in top two bits, type in low six.
// - Receiver routes packets by channel to four separate outputs.
// - Transmit channel number is programmable by the host.
// - Only 24-bit check code used; top two check bits are zero.
// - Check code input is identifier, low length byte, high length byte.
// - Header decoding outcome is shown to the application.
// - Type codes 0x38 to 0x3F are never sent nor accepted.
module clpf_framer (
  // System domain
  input  wire logic        sys_clk,
  input  wire logic        rst,
  // Channel programming, system domain
  input  wire logic        cfgChanWrite,
  input  wire logic [1:0]  cfgChan,
  // Error events, system domain pulses
  output logic             evtHdrFixed,
  output logic             evtHdrFatal,
  output logic             evtCrcErr,
  output logic             evtBadType,
  // Link byte clock
  input  wire logic        linkClk,
  // Receive bytes from the physical layer
  input  wire logic        lnkRxSot,
  input  wire logic        lnkRxEot,
  input  wire logic        lnkRxValid,
  input  wire logic [7:0]  lnkRxByte,
  // Transmit bytes to the physical layer
  output logic             lnkTxReq,
  output logic             lnkTxValid,
  output logic [7:0]       lnkTxByte,
  input  wire logic        lnkTxReady,
  // Received headers, link domain
  output logic             rxHdrValid,
  output logic [1:0]       rxHdrChan,
  output logic [5:0]       rxHdrType,
  output logic [15:0]      rxHdrField,
  output logic [1:0]       rxEccStatus,
  output logic [3:0]       rxShortValid,
  // Received payload per channel, link domain
  output logic [3:0]       rxPayValid,
  output logic [7:0]       rxPayByte,
  output logic [3:0]       rxPktEnd,
  output logic             rxCrcBad,
  // Transmit requests, link domain
  input  wire logic        txStart,
  input  wire logic [5:0]  txType,
  input  wire logic [15:0] txField,
  input  wire logic [7:0]  txPayByte,
  output logic             txPayReady,
  output logic             txBusy
);

  function automatic logic [5:0] eccCalc(input logic [23:0] d);
    logic [5:0] p;
    p = 6'h00;
    for (int i = 0; i < 24; i++) begin
      if (d[i]) begin
        p = p ^ clpf_pkg::ECC_SYN[i];
      end
    end
    return p;
  endfunction

  // Reflected shift so bit 0 of each byte enters first, as on the wire
  function automatic logic [15:0] crcStep(input logic [15:0] c, input logic [7:0] b);
    logic [15:0] r;
    r = c;
    for (int i = 0; i < 8; i++) begin
      r = (r[0] ^ b[i]) ? ((r >> 1) ^ clpf_pkg::CRC_POLY) : (r >> 1);
    end
    return r;
  endfunction

  function automatic logic isShort(input logic [5:0] t);
    return t <= clpf_pkg::TYPE_SHORT_MAX;
  endfunction

  function automatic logic isLong(input logic [5:0] t);
    return (t >= clpf_pkg::TYPE_LONG_MIN) && (t <= clpf_pkg::TYPE_LONG_MAX);
  endfunction

  function automatic logic [3:0] chanHot(input logic [1:0] ch);
    return 4'h1 << ch;
  endfunction

  // Channel setting: system side holds word, toggle announces a change
  logic [1:0] chanSys_q;
  logic       chanTgl_q;
  logic [2:0] chanSync_q;
  logic       chanSeen_q;
  logic [1:0] chanLink_q;

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      chanSys_q <= clpf_pkg::CHAN_RESET;
      chanTgl_q <= 1'b0;
    end else if (cfgChanWrite) begin
      chanSys_q <= cfgChan;
      chanTgl_q <= ~chanTgl_q;
    end
  end

  // Word is stable for many link cycles before the toggle is seen
  always_ff @(posedge linkClk or posedge rst) begin
    if (rst) begin
      chanSync_q <= 3'h0;
      chanSeen_q <= 1'b0;
      chanLink_q <= clpf_pkg::CHAN_RESET;
    end else begin
      chanSync_q <= {chanSync_q[1:0], chanTgl_q};
      if (chanSync_q[1] == chanSync_q[2] && chanSync_q[2] != chanSeen_q) begin
        chanSeen_q <= chanSync_q[2];
        chanLink_q <= chanSys_q;
      end
    end
  end

  // Error events: toggles on link side, three-stage sync on system side
  logic [clpf_pkg::EV_NUM-1:0] evTgl_q;
  logic [clpf_pkg::EV_NUM-1:0] evS0_q;
  logic [clpf_pkg::EV_NUM-1:0] evS1_q;
  logic [clpf_pkg::EV_NUM-1:0] evS2_q;
  logic [clpf_pkg::EV_NUM-1:0] evSeen_q;
  logic [clpf_pkg::EV_NUM-1:0] evOut_q;
  logic [clpf_pkg::EV_NUM-1:0] evNew;
  logic [clpf_pkg::EV_NUM-1:0] evHit;

  assign evNew = ~(evS1_q ^ evS2_q) & (evS2_q ^ evSeen_q);

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      evS0_q   <= '0;
      evS1_q   <= '0;
      evS2_q   <= '0;
      evSeen_q <= '0;
      evOut_q  <= '0;
    end else begin
      evS0_q   <= evTgl_q;
      evS1_q   <= evS0_q;
      evS2_q   <= evS1_q;
      evSeen_q <= evSeen_q ^ evNew;
      evOut_q  <= evNew;
    end
  end

  assign evtHdrFixed = evOut_q[clpf_pkg::EV_FIXED];
  assign evtHdrFatal = evOut_q[clpf_pkg::EV_FATAL];
  assign evtCrcErr   = evOut_q[clpf_pkg::EV_CRC];
  assign evtBadType  = evOut_q[clpf_pkg::EV_TYPE];

  // Receive side
  typedef enum logic [2:0] {
    RX_HUNT,
    RX_HDR,
    RX_PAY,
    RX_FTR,
    RX_WAIT_EOT
  } clpf_rx_t;

  clpf_rx_t            rxState_q;
  logic [15:0]         rxCnt_q;
  logic [23:0]         hdr_q;
  logic [15:0]         rxLen_q;
  logic [1:0]          rxChan_q;
  logic [15:0]         rxCrc_q;
  logic [7:0]          rxFtrLo_q;
  logic [31:0]         hdrWord;
  logic [7:0]          synd;
  logic [23:0]         hdrFix;
  clpf_pkg::clpf_ecc_t eccStat;
  logic                hdrDone;
  logic                payTake;
  logic                ftrDone;
  logic                crcBad;

  // Header bytes arrive identifier first, then low and high length byte
  always_comb begin
    hdrWord = {lnkRxByte, hdr_q};
    synd    = {hdrWord[31:30], hdrWord[29:24] ^ eccCalc(hdrWord[23:0])};
    hdrFix  = hdrWord[23:0];
    eccStat = clpf_pkg::ECC_OK;
    if (synd != 8'h00) begin
      eccStat = $onehot(synd) ? clpf_pkg::ECC_FIXED : clpf_pkg::ECC_FATAL;
      for (int i = 0; i < 24; i++) begin
        if (synd == {2'b00, clpf_pkg::ECC_SYN[i]}) begin
          hdrFix[i] = ~hdrWord[i];
          eccStat   = clpf_pkg::ECC_FIXED;
        end
      end
    end
  end

  assign hdrDone = (rxState_q == RX_HDR) && lnkRxValid && !lnkRxEot
                   && (rxCnt_q[1:0] == clpf_pkg::HDR_LAST);
  assign payTake = (rxState_q == RX_PAY) && lnkRxValid && !lnkRxEot;
  assign ftrDone = (rxState_q == RX_FTR) && lnkRxValid && !lnkRxEot && rxCnt_q[0];
  assign crcBad  = {lnkRxByte, rxFtrLo_q} != rxCrc_q;

  always_ff @(posedge linkClk or posedge rst) begin
    if (rst) begin
      rxState_q <= RX_HUNT;
      rxCnt_q   <= 16'h0000;
      hdr_q     <= 24'h00_0000;
      rxLen_q   <= 16'h0000;
      rxChan_q  <= 2'h0;
      rxCrc_q   <= clpf_pkg::CRC_SEED;
      rxFtrLo_q <= 8'h00;
    end else if (lnkRxEot) begin
      rxState_q <= RX_HUNT;
    end else begin
      case (rxState_q)
        RX_HUNT: begin
          if (lnkRxSot) begin
            rxState_q <= RX_HDR;
            rxCnt_q   <= 16'h0000;
          end
        end
        RX_HDR: begin
          if (lnkRxValid && !hdrDone) begin
            hdr_q[8*rxCnt_q[1:0] +: 8] <= lnkRxByte;
            rxCnt_q <= rxCnt_q + 16'h0001;
          end
          if (hdrDone) begin
            rxCnt_q  <= 16'h0000;
            rxCrc_q  <= clpf_pkg::CRC_SEED;
            rxLen_q  <= hdrFix[23:8];
            rxChan_q <= hdrFix[clpf_pkg::DI_CHAN_MSB:clpf_pkg::DI_CHAN_LSB];
            if (eccStat == clpf_pkg::ECC_FATAL) begin
              rxState_q <= RX_WAIT_EOT;
            end else if (isLong(hdrFix[clpf_pkg::DI_TYPE_MSB:clpf_pkg::DI_TYPE_LSB])) begin
              rxState_q <= (hdrFix[23:8] == 16'h0000) ? RX_FTR : RX_PAY;
            end else begin
              rxState_q <= RX_WAIT_EOT;
            end
          end
        end
        RX_PAY: begin
          // Any byte value is payload here, nothing is searched for
          if (payTake) begin
            rxCrc_q <= crcStep(rxCrc_q, lnkRxByte);
            rxCnt_q <= rxCnt_q + 16'h0001;
            if (rxCnt_q + 16'h0001 == rxLen_q) begin
              rxState_q <= RX_FTR;
              rxCnt_q   <= 16'h0000;
            end
          end
        end
        RX_FTR: begin
          if (lnkRxValid) begin
            rxFtrLo_q <= lnkRxByte;
            rxCnt_q   <= 16'h0001;
          end
          if (ftrDone) begin
            rxState_q <= RX_WAIT_EOT;
          end
        end
        RX_WAIT_EOT: begin
          rxState_q <= RX_WAIT_EOT;
        end
        default: begin
          rxState_q <= RX_HUNT;
        end
      endcase
    end
  end

  // Receive outputs and event toggles
  always_ff @(posedge linkClk or posedge rst) begin
    if (rst) begin
      rxHdrValid   <= 1'b0;
      rxHdrChan    <= 2'h0;
      rxHdrType    <= 6'h00;
      rxHdrField   <= 16'h0000;
      rxEccStatus  <= clpf_pkg::ECC_OK;
      rxShortValid <= 4'h0;
      rxPayValid   <= 4'h0;
      rxPayByte    <= 8'h00;
      rxPktEnd     <= 4'h0;
      rxCrcBad     <= 1'b0;
      evTgl_q      <= '0;
    end else begin
      rxHdrValid   <= hdrDone;
      rxShortValid <= 4'h0;
      rxPayValid   <= payTake ? chanHot(rxChan_q) : 4'h0;
      rxPktEnd     <= 4'h0;
      if (payTake) begin
        rxPayByte <= lnkRxByte;
      end
      if (hdrDone) begin
        rxHdrChan   <= hdrFix[clpf_pkg::DI_CHAN_MSB:clpf_pkg::DI_CHAN_LSB];
        rxHdrType   <= hdrFix[clpf_pkg::DI_TYPE_MSB:clpf_pkg::DI_TYPE_LSB];
        rxHdrField  <= hdrFix[23:8];
        rxEccStatus <= eccStat;
        if (eccStat == clpf_pkg::ECC_FIXED) begin
          evTgl_q[clpf_pkg::EV_FIXED] <= ~evTgl_q[clpf_pkg::EV_FIXED];
        end
        if (eccStat == clpf_pkg::ECC_FATAL) begin
          evTgl_q[clpf_pkg::EV_FATAL] <= ~evTgl_q[clpf_pkg::EV_FATAL];
        end else if (isShort(hdrFix[clpf_pkg::DI_TYPE_MSB:clpf_pkg::DI_TYPE_LSB])) begin
          rxShortValid <= chanHot(hdrFix[clpf_pkg::DI_CHAN_MSB:clpf_pkg::DI_CHAN_LSB]);
        end else if (hdrFix[clpf_pkg::DI_TYPE_MSB:clpf_pkg::DI_TYPE_LSB]
                     >= clpf_pkg::TYPE_RSVD_MIN) begin
          evTgl_q[clpf_pkg::EV_TYPE] <= ~evTgl_q[clpf_pkg::EV_TYPE];
        end
      end
      if (ftrDone) begin
        rxPktEnd <= chanHot(rxChan_q);
        rxCrcBad <= crcBad;
        if (crcBad) begin
          evTgl_q[clpf_pkg::EV_CRC] <= ~evTgl_q[clpf_pkg::EV_CRC];
        end
      end
    end
  end

  // Transmit side
  typedef enum logic [1:0] {
    TX_IDLE,
    TX_REQ,
    TX_SEND,
    TX_END
  } clpf_tx_t;

  clpf_tx_t    txState_q;
  logic [31:0] txHdr_q;
  logic        txLong_q;
  logic [16:0] txIdx_q;
  logic [15:0] txCrc_q;
  logic [16:0] txPayEnd;
  logic [16:0] txLast;
  logic [16:0] txIdxNext;
  logic [23:0] txHdrData;
  logic [7:0]  txSel;

  assign txHdrData = {txField, chanLink_q, txType};
  assign txPayEnd  = clpf_pkg::HDR_BYTES + {1'b0, txHdr_q[23:8]};
  assign txLast    = (txLong_q ? txPayEnd + clpf_pkg::FTR_BYTES : clpf_pkg::HDR_BYTES)
                     - 17'h0_0001;
  assign txIdxNext = txIdx_q + 17'h0_0001;

  // Bit 0 of each byte is the first bit the serialiser puts on the wire
  always_comb begin
    if (txIdx_q < clpf_pkg::HDR_BYTES) begin
      txSel = txHdr_q[8*txIdx_q[1:0] +: 8];
    end else if (txIdx_q < txPayEnd) begin
      txSel = txPayByte;
    end else if (txIdx_q == txPayEnd) begin
      txSel = txCrc_q[7:0];
    end else begin
      txSel = txCrc_q[15:8];
    end
  end

  always_ff @(posedge linkClk or posedge rst) begin
    if (rst) begin
      txState_q  <= TX_IDLE;
      txHdr_q    <= 32'h0000_0000;
      txLong_q   <= 1'b0;
      txIdx_q    <= 17'h0_0000;
      txCrc_q    <= clpf_pkg::CRC_SEED;
      txBusy     <= 1'b0;
      txPayReady <= 1'b0;
      lnkTxReq   <= 1'b0;
      lnkTxValid <= 1'b0;
      lnkTxByte  <= 8'h00;
    end else begin
      case (txState_q)
        TX_IDLE: begin
          // Reserved types are refused; the request is simply dropped
          if (txStart && txType < clpf_pkg::TYPE_RSVD_MIN) begin
            txHdr_q   <= {2'b00, eccCalc(txHdrData), txHdrData};
            txLong_q  <= isLong(txType);
            txCrc_q   <= clpf_pkg::CRC_SEED;
            txIdx_q   <= 17'h0_0000;
            txBusy    <= 1'b1;
            lnkTxReq  <= 1'b1;
            txState_q <= TX_REQ;
          end
        end
        TX_REQ: begin
          if (lnkTxReady) begin
            txState_q <= TX_SEND;
          end
        end
        TX_SEND: begin
          lnkTxValid <= 1'b1;
          lnkTxByte  <= txSel;
          txIdx_q    <= txIdxNext;
          if (txPayReady) begin
            txCrc_q <= crcStep(txCrc_q, txPayByte);
          end
          txPayReady <= (txIdx_q != txLast) && txLong_q
                        && (txIdxNext >= clpf_pkg::HDR_BYTES) && (txIdxNext < txPayEnd);
          if (txIdx_q == txLast) begin
            txState_q <= TX_END;
          end
        end
        TX_END: begin
          // Dropping the request lets the physical layer end and idle
          lnkTxValid <= 1'b0;
          lnkTxReq   <= 1'b0;
          txBusy     <= 1'b0;
          txState_q  <= TX_IDLE;
        end
        default: begin
          txState_q <= TX_IDLE;
        end
      endcase
    end
  end

endmodule

// ==== clpf_framer_checker.sv ====
// Concurrent port checks for the packet framer.
// Assumes a bind onto clpf_framer; all checks on linkClk.
`timescale 1ns/10ps
module clpf_framer_checker (
  // Clock and reset
  input wire logic        linkClk,
  input wire logic        rst,
  // Link side
  input wire logic        lnkRxEot,
  input wire logic        lnkTxReq,
  input wire logic        lnkTxValid,
  input wire logic [7:0]  lnkTxByte,
  // Received packets
  input wire logic        rxHdrValid,
  input wire logic [1:0]  rxHdrChan,
  input wire logic [5:0]  rxHdrType,
  input wire logic [15:0] rxHdrField,
  input wire logic [1:0]  rxEccStatus,
  input wire logic [3:0]  rxShortValid,
  input wire logic [3:0]  rxPayValid,
  input wire logic [3:0]  rxPktEnd,
  // Transmit requests
  input wire logic        txStart,
  input wire logic [5:0]  txType,
  input wire logic [15:0] txField,
  input wire logic        txBusy
);
  logic        takeTx;
  logic [16:0] txCnt_q;
  logic [5:0]  type_q;
  logic [15:0] field_q;
  logic [15:0] payCnt_q;

  assign takeTx = txStart && !txBusy && (txType < 6'h38);

  // Byte index of the packet on the transmit side
  always_ff @(posedge linkClk or posedge rst) begin
    if (rst) begin
      txCnt_q <= '0;
      type_q  <= '0;
      field_q <= '0;
    end else if (takeTx) begin
      txCnt_q <= '0;
      type_q  <= txType;
      field_q <= txField;
    end else if (lnkTxValid) begin
      txCnt_q <= txCnt_q + 17'h0_0001;
    end
  end

  // Payload bytes delivered since the last header
  always_ff @(posedge linkClk or posedge rst) begin
    if (rst) begin
      payCnt_q <= '0;
    end else if (rxHdrValid) begin
      payCnt_q <= '0;
    end else if (rxPayValid != 4'h0) begin
      payCnt_q <= payCnt_q + 16'h0001;
    end
  end

  default clocking cb @(posedge linkClk); endclocking
  default disable iff (rst);

  a_tx_accept: assert property (
    takeTx |=> txBusy && lnkTxReq) else $error("transmit start not taken");
  a_rsvd_refused: assert property (
    txStart && !txBusy && txType >= 6'h38 |=> !txBusy && !lnkTxReq)
    else $error("reserved type was sent");
  a_id_type: assert property (
    lnkTxValid && txCnt_q == 17'h0_0000 |-> lnkTxByte[5:0] == type_q)
    else $error("identifier byte type wrong");
  a_field_order: assert property (
    lnkTxValid && txCnt_q == 17'h0_0001 |-> lnkTxByte == field_q[7:0]
    ##1 lnkTxValid && lnkTxByte == field_q[15:8]) else $error("field bytes out of order");
  a_ecc_top: assert property (
    lnkTxValid && txCnt_q == 17'h0_0003 |-> lnkTxByte[7:6] == 2'b00)
    else $error("check byte top bits set");
  a_tx_length: assert property (
    $fell(lnkTxValid) |-> !lnkTxReq && txCnt_q == ((type_q <= 6'h0F) ? 17'h0_0004
    : {1'b0, field_q} + 17'h0_0006)) else $error("packet length wrong");
  a_short_route: assert property (
    rxShortValid != 4'h0 |-> rxHdrValid && rxShortValid == (4'h1 << rxHdrChan)
    && rxHdrType <= 6'h0F) else $error("short packet misrouted");
  a_pay_route: assert property (
    rxPayValid != 4'h0 |-> rxPayValid == (4'h1 << rxHdrChan)
    && rxHdrType inside {[6'h10:6'h37]}) else $error("payload misrouted");
  a_pay_count: assert property (
    rxPktEnd != 4'h0 |-> payCnt_q == rxHdrField && rxPktEnd == (4'h1 << rxHdrChan))
    else $error("payload count wrong");
  a_eot_quiet: assert property (
    lnkRxEot |=> rxPayValid == 4'h0 && rxPktEnd == 4'h0) else $error("bytes after end");
  a_fatal_drop: assert property (
    rxHdrValid && rxEccStatus == clpf_pkg::ECC_FATAL |-> rxShortValid == 4'h0
    ##1 rxPayValid == 4'h0) else $error("bad header not dropped");
endmodule

// ==== clpf_phy_model.sv ====
// Byte link model looping transmit bytes back to receive.
// Assumes one framer on both ends; stalls ready, corrupts a byte.
`timescale 1ns/10ps
module clpf_phy_model (
  // Clock and reset
  input wire logic       linkClk,
  input wire logic       rst,
  // Framer transmit side
  input wire logic       lnkTxReq,
  input wire logic       lnkTxValid,
  input wire logic [7:0] lnkTxByte,
  output logic           lnkTxReady,
  // Framer receive side
  output logic           lnkRxSot,
  output logic           lnkRxEot,
  output logic           lnkRxValid,
  output logic [7:0]     lnkRxByte,
  // Stall and corruption controls
  input wire logic [3:0] readyDelay,
  input wire logic [7:0] flipIdx,
  input wire logic [7:0] flipByte
);
  logic [3:0] wait_q;
  logic [7:0] idx_q;
  logic       req_q;

  always @(posedge linkClk or posedge rst) begin
    if (rst) begin
      {lnkTxReady, lnkRxSot, lnkRxEot, lnkRxValid, req_q} <= 5'h00;
      lnkRxByte <= 8'h00;
      wait_q    <= 4'h0;
      idx_q     <= 8'h00;
    end else begin
      req_q    <= lnkTxReq;
      lnkRxSot <= lnkTxReq && !req_q;
      lnkRxEot <= req_q && !lnkTxReq;
      if (!lnkTxReq) begin
        wait_q     <= 4'h0;
        lnkTxReady <= 1'b0;
        idx_q      <= 8'h00;
      end else if (wait_q < readyDelay) begin
        wait_q <= wait_q + 4'h1;
      end else begin
        lnkTxReady <= 1'b1;
      end
      lnkRxValid <= lnkTxValid;
      // Released line toggles so a stale byte never looks valid
      if (lnkTxValid) begin
        lnkRxByte <= lnkTxByte ^ ((idx_q == flipIdx) ? flipByte : 8'h00);
        idx_q     <= idx_q + 8'h01;
      end else begin
        lnkRxByte <= ~lnkRxByte;
      end
    end
  end
endmodule

// ==== test_camera_link_packet_framer.sv ====
// Self-checking bench for the camera link packet framer in loopback.
// Assumes clpf_pkg, the link model and the checker are compiled first.
`timescale 1ns/10ps
module test_camera_link_packet_framer;
  logic        sys_clk = 1'b0, linkClk = 1'b0, rst = 1'b1;
  logic        cfgChanWrite = 1'b0, txStart = 1'b0;
  logic [1:0]  cfgChan = 2'h0;
  logic [5:0]  txType = 6'h00;
  logic [15:0] txField = 16'h0000;
  logic [7:0]  txPayByte = 8'h00, flipIdx = 8'hFF, flipByte = 8'h00;
  logic [3:0]  readyDelay = 4'h0;
  logic        evtHdrFixed, evtHdrFatal, evtCrcErr, evtBadType, rxHdrValid, rxCrcBad;
  logic        lnkRxSot, lnkRxEot, lnkRxValid, lnkTxReq, lnkTxValid, lnkTxReady;
  logic        txPayReady, txBusy;
  logic [7:0]  lnkRxByte, lnkTxByte, rxPayByte;
  logic [1:0]  rxHdrChan, rxEccStatus;
  logic [5:0]  rxHdrType;
  logic [15:0] rxHdrField;
  logic [3:0]  rxShortValid, rxPayValid, rxPktEnd, shortSeen, endSeen, payCh;
  logic [7:0]  payArr [16];
  logic [7:0]  txSeen [$];
  logic [7:0]  payRx [$];
  int          fails = 0, n_compared = 0, pIdx = 0, nFixed = 0, nFatal = 0, nCrc = 0, nBad = 0;

  always #5 sys_clk = ~sys_clk;
  always #80 linkClk = ~linkClk;

  clpf_framer DUT (.*);
  clpf_phy_model phy (.*);

  always @(negedge linkClk) begin
    if (lnkTxValid === 1'b1) txSeen.push_back(lnkTxByte);
    if (rxShortValid !== 4'h0) shortSeen = rxShortValid;
    if (rxPayValid !== 4'h0) begin
      payRx.push_back(rxPayByte);
      payCh = rxPayValid;
    end
    if (rxPktEnd !== 4'h0) endSeen = rxPktEnd;
  end

  always @(negedge sys_clk) begin
    if (evtHdrFixed === 1'b1) nFixed++;
    if (evtHdrFatal === 1'b1) nFatal++;
    if (evtCrcErr === 1'b1) nCrc++;
    if (evtBadType === 1'b1) nBad++;
  end

  // Payload byte must already stand when the framer takes it
  always @(posedge linkClk) begin
    #1;
    if (txPayReady === 1'b1 && pIdx < 16) begin
      txPayByte = payArr[pIdx];
      pIdx++;
    end
  end

  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    n_compared++;
    if (got !== exp) begin
      fails++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask

  function automatic logic [7:0] eccOf(input logic [23:0] d);
    logic [5:0] p;
    p = 6'h00;
    for (int i = 0; i < 24; i++) if (d[i]) p ^= clpf_pkg::ECC_SYN[i];
    return {2'b00, p};
  endfunction

  function automatic logic [15:0] crcOf(input int n);
    logic [15:0] c;
    c = clpf_pkg::CRC_SEED;
    for (int i = 0; i < n; i++) begin
      for (int b = 0; b < 8; b++) begin
        c = (c >> 1) ^ ((c[0] ^ payArr[i][b]) ? clpf_pkg::CRC_POLY : 16'h0000);
      end
    end
    return c;
  endfunction

  task automatic setChan(input logic [1:0] ch);
    @(posedge sys_clk);
    #1;
    cfgChan = ch;
    cfgChanWrite = 1'b1;
    @(posedge sys_clk);
    #1;
    cfgChanWrite = 1'b0;
    repeat (8) @(posedge linkClk);
  endtask

  task automatic send(input logic [1:0] ch, input logic [5:0] ty, input logic [15:0] fld,
                      input logic [7:0] fIdx, input logic [7:0] fByte);
    int n, len, tot;
    logic [15:0] c;
    len = (ty <= 6'h0F) ? 0 : int'(fld);
    tot = len + ((ty <= 6'h0F) ? 4 : 6);
    txSeen.delete();
    payRx.delete();
    {shortSeen, endSeen, payCh} = 12'h000;
    n = 0;
    pIdx = 0;
    flipIdx = fIdx;
    flipByte = fByte;
    @(posedge linkClk);
    #1;
    txType = ty;
    txField = fld;
    txStart = 1'b1;
    @(posedge linkClk);
    #1;
    txStart = 1'b0;
    while (txBusy !== 1'b0 && n < 100) begin
      @(posedge linkClk);
      n++;
    end
    repeat (4) @(posedge linkClk);
    chk("tx busy", 16'h0000, 16'(txBusy));
    chk("tx count", 16'(tot), 16'(txSeen.size()));
    if (txSeen.size() != tot) return;
    chk("id byte", 16'({ch, ty}), 16'(txSeen[0]));
    chk("field lo", 16'(fld[7:0]), 16'(txSeen[1]));
    chk("field hi", 16'(fld[15:8]), 16'(txSeen[2]));
    chk("check byte", 16'(eccOf({fld, ch, ty})), 16'(txSeen[3]));
    for (int i = 0; i < len; i++) chk("tx payload", 16'(payArr[i]), 16'(txSeen[4 + i]));
    c = crcOf(len);
    if (ty >= 6'h10) begin
      chk("footer lo", 16'(c[7:0]), 16'(txSeen[len + 4]));
      chk("footer hi", 16'(c[15:8]), 16'(txSeen[len + 5]));
    end
  endtask

  task automatic t_short();
    logic [5:0]  ty [4] = '{6'h00, 6'h02, 6'h08, 6'h0F};
    logic [15:0] fv [4] = '{16'h0001, 16'h0BEF, 16'hA55A, 16'hFFFF};
    for (int i = 0; i < 4; i++) begin
      setChan(2'(i));
      send(2'(i), ty[i], fv[i], 8'hFF, 8'h00);
      chk("short route", 16'(4'h1 << i), 16'(shortSeen));
      chk("short data", fv[i], rxHdrField);
      chk("short status", 16'(clpf_pkg::ECC_OK), 16'(rxEccStatus));
      chk("no footer", 16'h0000, 16'(endSeen));
    end
  endtask

  task automatic t_long();
    for (int i = 0; i < 16; i++) payArr[i] = 8'(i * 8'h55);
    setChan(2'h1);
    for (int k = 0; k < 2; k++) begin
      readyDelay = k ? 4'h6 : 4'h0;
      send(2'h1, k ? 6'h37 : 6'h10, k ? 16'h0007 : 16'h0000, 8'hFF, 8'h00);
      chk("payload count", k ? 16'h0007 : 16'h0000, 16'(payRx.size()));
      for (int i = 0; i < payRx.size(); i++) chk("rx payload", 16'(payArr[i]), 16'(payRx[i]));
      chk("end route", 16'h0002, 16'(endSeen));
      chk("crc flag", 16'h0000, 16'(rxCrcBad));
    end
    chk("payload route", 16'h0002, 16'(payCh));
  endtask

  task automatic t_err();
    int f0, f1, c0;
    f0 = nFixed;
    f1 = nFatal;
    c0 = nCrc;
    readyDelay = 4'h2;
    send(2'h1, 6'h09, 16'h1234, 8'h01, 8'h04);
    chk("fixed status", 16'(clpf_pkg::ECC_FIXED), 16'(rxEccStatus));
    chk("fixed data", 16'h1234, rxHdrField);
    chk("fixed event", 16'(f0 + 1), 16'(nFixed));
    send(2'h1, 6'h09, 16'h1234, 8'h00, 8'h03);
    chk("fatal status", 16'(clpf_pkg::ECC_FATAL), 16'(rxEccStatus));
    chk("fatal dropped", 16'h0000, 16'(shortSeen));
    chk("fatal event", 16'(f1 + 1), 16'(nFatal));
    send(2'h1, 6'h2A, 16'h0004, 8'h05, 8'h80);
    chk("crc bad flag", 16'h0001, 16'(rxCrcBad));
    chk("crc event", 16'(c0 + 1), 16'(nCrc));
  endtask

  task automatic t_refuse();
    for (int k = 0; k < 2; k++) begin
      @(posedge linkClk);
      #1;
      txType = k ? 6'h3F : 6'h38;
      txStart = 1'b1;
      @(posedge linkClk);
      #1;
      txStart = 1'b0;
      @(posedge linkClk);
      #1;
      chk("reserved refused", 16'h0000, 16'({txBusy, lnkTxReq}));
    end
    chk("bad type event", 16'h0000, 16'(nBad));
  endtask

  task automatic test_done();
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  initial begin
    repeat (6) @(posedge linkClk);
    #1;
    rst = 1'b0;
    repeat (2) @(posedge linkClk);
    t_short();
    t_long();
    t_err();
    t_refuse();
    test_done();
  end

  // Whole run needs about 33 us
  initial begin
    #400000;
    fails++;
    test_done();
  end
endmodule

bind clpf_framer clpf_framer_checker chk_i (.*);
